// >>> common/buck_pkg.sv
package buck_pkg;

   localparam int CLK_HZ          = 25_000_000;
   localparam int CLK_NS          = 40;
   localparam int SW_RATE_KHZ     = 1000;
   localparam int PERIOD_CYC      = CLK_HZ / (SW_RATE_KHZ * 1000);
   localparam int MIN_OFF_NS      = 65;
   localparam int MIN_OFF_CYC     = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int MAX_ON_NS       = 6600;
   localparam int MAX_ON_CYC      = MAX_ON_NS / CLK_NS;
   localparam int RETRY_ON_CYCLES = 512;
   localparam int RETRY_OFF_MS    = 60;
   localparam int RETRY_OFF_CYC   = RETRY_OFF_MS * (CLK_HZ / 1000);
   localparam int SS_US           = 500;
   localparam int SS_CYC          = SS_US * (CLK_HZ / 1_000_000);
   localparam int DIM_OFF_MS      = 36;
   localparam int DIM_OFF_CYC     = DIM_OFF_MS * (CLK_HZ / 1000);

   localparam int           REF_W         = 10;
   localparam logic [9:0]   REF_FULL      = 10'h3FF;
   localparam int           DUTY_WIN_LOG2 = 18;
   localparam logic [7:0]   DUTY_FULL     = 8'h80;
   localparam int           DUTY_MIN_PCT  = 1;
   localparam logic [7:0]   DUTY_MIN      = 8'((DUTY_MIN_PCT * 128 + 99) / 100);

   typedef enum logic [1:0] {sw_idle, sw_on, sw_low, sw_sink_off} sw_state_t;

   // Reference = ramp * duty / 128, duty clamped into its usable span
   function automatic logic [9:0] scale_ref(input logic [9:0] ramp, input logic [7:0] duty);
      logic [7:0]  d;
      logic [17:0] p;
      d = (duty < DUTY_MIN) ? DUTY_MIN : ((duty > DUTY_FULL) ? DUTY_FULL : duty);
      p = 18'(ramp) * 18'(d);
      return p[16:7];
   endfunction

endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,    // Core clock
   input  wire logic         sys_rst, // Async reset, high
   input  wire logic [W-1:0] pin,     // Asynchronous inputs
   output logic      [W-1:0] level    // Filtered, synchronous
);
   logic [W-1:0] s1, s2, s3;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         level <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
               level[i] <= s3[i];
            end
         end
      end
   end
endmodule // pin_sync

// >>> verilog/soft_start_ramp.sv
`timescale 1ns/1ps
module soft_start_ramp #(
   parameter int RAMP_CYC = buck_pkg::SS_CYC
) (
   input  wire logic       mclk,    // Core clock
   input  wire logic       sys_rst, // Async reset, high
   input  wire logic       restart, // Hold ramp at zero
   output logic      [9:0] ramp     // Reference ramp code
);
   localparam int STEP = (RAMP_CYC / 1024 < 1) ? 1 : RAMP_CYC / 1024;
   logic [15:0] tick;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= '0;
         ramp <= '0;
      end else if (restart) begin
         tick <= '0;
         ramp <= '0;
      end else if (ramp != buck_pkg::REF_FULL) begin
         if (tick == 16'(STEP - 1)) begin
            tick <= '0;
            ramp <= ramp + 10'h001;
         end else begin
            tick <= tick + 16'h0001;
         end
      end
   end
endmodule // soft_start_ramp

// >>> verilog/buck_switch_control_hiccup.sv
`timescale 1ns/1ps
// How it works
// [R1] Overcurrent past 512 cycles enters hiccup
// [R2] Hiccup shutdown lasts the 60 ms off-time
// [R3] Soft start ramps reference over 0.5 ms
// [R4] Cycles start at 1 MHz after min off-time
// [R5] Peak compare: high side off, low on
// [R6] Low side stays on until cycle end
// [R7] Minimum off-time enforced every cycle
// [R8] On-time stretches up to 6.6 us
// [R9] High-side limit: high off, low on
// [R10] Source limit at cycle end skips turn-on
// [R11] Turn-on resumes once source current is low
// [R12] Sink limit turns both switches off
// [R13] After sink event, restart at clean cycle
// [R14] Supply lockout stops all switching
// [R15] Current limit or feedback overvoltage starts hiccup
// [R16] Gating variant follows dimming input phases
// [R17] Scaling variant sets reference from duty
// [R18] Long dimming low disables the device
// [R19] Hiccup holds switches off, then restarts
// [R20] Never both switch drives on together
module buck_switch_control_hiccup #(
   parameter int RETRY_OFF_CYC = buck_pkg::RETRY_OFF_CYC,
   parameter int SS_CYC        = buck_pkg::SS_CYC,
   parameter int DIM_OFF_CYC   = buck_pkg::DIM_OFF_CYC
) (
   input  wire logic       mclk,                    // 25 MHz core clock
   input  wire logic       sys_rst,                 // Async reset, high
   input  wire logic       peak_compare,            // Sensed current reached error level
   input  wire logic       high_side_current_limit, // High-side limit comparator
   input  wire logic       low_side_source_limit,   // Low-side sourcing limit comparator
   input  wire logic       low_side_sink_limit,     // Low-side sinking limit comparator
   input  wire logic       supply_lockout,          // Supply below lockout threshold
   input  wire logic       feedback_pin_ovp,        // Feedback overvoltage comparator
   input  wire logic       dimming_input,           // Digital dimming pin
   input  wire logic       duty_scale_variant,      // Strap: 1 = duty scales reference
   output logic            high_side_on,            // High-side gate drive
   output logic            low_side_on,             // Low-side gate drive
   output logic      [9:0] reference_level,         // Reference code to error amp
   output logic            hiccup_active,           // In hiccup shutdown
   output logic            dim_disabled             // Disabled by long dimming low
);
   localparam int P = buck_pkg::PERIOD_CYC;

   logic                  peak_s, hs_lim_s, src_s, sink_s;
   logic                  lock_s, ovp_s, dim_s, strap_s;
   logic                  variant, strap_taken;
   buck_pkg::sw_state_t   state, next_state;
   logic [7:0]            cycle_cnt, on_cnt, off_cnt;
   logic                  start_now, run, next_hs, next_ls;
   logic                  oc_seen, enter_hiccup;
   logic [9:0]            retry_cnt;
   logic [23:0]           off_timer, dim_low_cnt;
   logic [9:0]            ramp;
   logic [17:0]           win_cnt, high_cnt;
   logic [7:0]            duty;

   pin_sync #(
      .W (8)
   ) u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .pin     ({peak_compare, high_side_current_limit, low_side_source_limit,
                 low_side_sink_limit, supply_lockout, feedback_pin_ovp,
                 dimming_input, duty_scale_variant}),
      .level   ({peak_s, hs_lim_s, src_s, sink_s, lock_s, ovp_s, dim_s, strap_s})
   );

   // Strap is taken once, a few cycles after reset release
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         variant     <= 1'b0;
         strap_taken <= 1'b0;
      end else if (!strap_taken && cycle_cnt == 8'h04) begin
         variant     <= strap_s;
         strap_taken <= 1'b1;
      end
   end

   // Switching is allowed only with supply good, not dimmed off, no hiccup
   assign run = !lock_s && !dim_disabled && !hiccup_active && !enter_hiccup
                && (variant || dim_s); // R14 R16 R19

   // New cycle at the nominal period, but never inside the on-time or min off
   assign start_now = (cycle_cnt >= 8'(P - 1)) && (state != buck_pkg::sw_on)
                      && (off_cnt >= 8'(buck_pkg::MIN_OFF_CYC)); // R4 R7

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cycle_cnt <= '0;
      end else if (start_now) begin
         cycle_cnt <= '0;
      end else if (cycle_cnt != 8'hFF) begin
         cycle_cnt <= cycle_cnt + 8'h01;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         buck_pkg::sw_on: begin
            if (peak_s || hs_lim_s) begin
               next_state = buck_pkg::sw_low; // R5 R9
            end else if (on_cnt >= 8'(buck_pkg::MAX_ON_CYC - 1)) begin
               next_state = buck_pkg::sw_low; // R8
            end
         end
         buck_pkg::sw_low: begin
            if (sink_s) begin
               next_state = buck_pkg::sw_sink_off; // R12
            end else if (start_now) begin
               next_state = buck_pkg::sw_idle; // R6
            end
         end
         default: begin
            if (start_now) begin
               next_state = buck_pkg::sw_idle;
            end
         end
      endcase
      // Cycle start decides the new on-phase
      if (start_now) begin
         if (src_s) begin
            next_state = buck_pkg::sw_low; // R10 R11
         end else if (sink_s) begin
            next_state = buck_pkg::sw_sink_off; // R13
         end else begin
            next_state = buck_pkg::sw_on;
         end
      end
      if (!run) begin
         next_state = buck_pkg::sw_idle; // R14 R19
      end
   end

   // Both drives come from the one state value, so they cannot overlap
   assign next_hs = (next_state == buck_pkg::sw_on);  // R20
   assign next_ls = (next_state == buck_pkg::sw_low); // R20

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state        <= buck_pkg::sw_idle;
         high_side_on <= 1'b0;
         low_side_on  <= 1'b0;
      end else begin
         state        <= next_state;
         high_side_on <= next_hs;
         low_side_on  <= next_ls;
      end
   end

   // On and off durations for stretching and min off-time
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         on_cnt  <= '0;
         off_cnt <= 8'(buck_pkg::MIN_OFF_CYC);
      end else begin
         if (next_state == buck_pkg::sw_on) begin
            on_cnt <= (state == buck_pkg::sw_on) ? on_cnt + 8'h01 : 8'h00; // R8
         end else begin
            on_cnt <= '0;
         end
         if (next_state == buck_pkg::sw_on) begin
            off_cnt <= '0;
         end else if (off_cnt != 8'hFF) begin
            off_cnt <= off_cnt + 8'h01; // R7
         end
      end
   end

   // Count consecutive cycles with a limit or overvoltage event
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         oc_seen   <= 1'b0;
         retry_cnt <= '0;
      end else if (!run) begin
         oc_seen   <= 1'b0;
         retry_cnt <= '0;
      end else if (start_now) begin
         oc_seen   <= 1'b0;
         if (oc_seen || hs_lim_s || src_s || sink_s || ovp_s) begin
            if (retry_cnt != 10'h3FF) begin
               retry_cnt <= retry_cnt + 10'h001; // R1 R15
            end
         end else begin
            retry_cnt <= '0;
         end
      end else if (hs_lim_s || src_s || sink_s || ovp_s) begin
         oc_seen <= 1'b1; // R15
      end
   end

   // Entry also stops switching at once, so the drives fall with hiccup_active
   assign enter_hiccup = !hiccup_active && (retry_cnt > 10'(buck_pkg::RETRY_ON_CYCLES)); // R1 R19

   // Hiccup: shut down past the on-count, restart after the off-timer
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hiccup_active <= 1'b0;
         off_timer     <= '0;
      end else if (hiccup_active) begin
         if (off_timer >= 24'(RETRY_OFF_CYC - 1)) begin
            hiccup_active <= 1'b0; // R2 R19
            off_timer     <= '0;
         end else begin
            off_timer <= off_timer + 24'h000001;
         end
      end else if (retry_cnt > 10'(buck_pkg::RETRY_ON_CYCLES)) begin
         hiccup_active <= 1'b1; // R1
      end
   end

   // A low dimming level longer than the disable time shuts the device off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dim_low_cnt  <= '0;
         dim_disabled <= 1'b0;
      end else if (dim_s) begin
         dim_low_cnt  <= '0;
         dim_disabled <= 1'b0;
      end else if (dim_low_cnt >= 24'(DIM_OFF_CYC - 1)) begin
         dim_disabled <= 1'b1; // R18
      end else begin
         dim_low_cnt <= dim_low_cnt + 24'h000001;
      end
   end

   // Duty over a fixed window; avoids a divider at the cost of window latency
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         win_cnt  <= '0;
         high_cnt <= '0;
         duty     <= buck_pkg::DUTY_FULL;
      end else begin
         win_cnt <= win_cnt + 18'h00001;
         if (win_cnt == 18'h3FFFF) begin
            duty     <= {1'b0, high_cnt[17:11]} + {7'h00, (dim_s & (&high_cnt))}; // R17
            high_cnt <= '0;
         end else if (dim_s) begin
            high_cnt <= high_cnt + 18'h00001;
         end
      end
   end

   // Ramp restarts on supply lockout, long dimming disable or hiccup
   soft_start_ramp #(
      .RAMP_CYC (SS_CYC)
   ) u_ss (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .restart (lock_s || dim_disabled || hiccup_active), // R3
      .ramp    (ramp)
   );

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reference_level <= '0;
      end else if (variant) begin
         reference_level <= buck_pkg::scale_ref(ramp, duty); // R17
      end else begin
         reference_level <= ramp; // R3
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   chk_no_overlap: assert property (!(high_side_on && low_side_on)) // R20
      else $error("both switch drives on");
   chk_peak_turnoff: assert property ( // R5
      (state == buck_pkg::sw_on && peak_s && run && !start_now) |=> (!high_side_on && low_side_on))
      else $error("peak compare did not swap switches");
   chk_hs_limit_off: assert property ( // R9
      (state == buck_pkg::sw_on && hs_lim_s && run) |=> !high_side_on ##0 low_side_on)
      else $error("high-side limit did not swap switches");
   chk_low_hold: assert property ( // R6
      (state == buck_pkg::sw_low && !sink_s && run && !start_now) |=> low_side_on)
      else $error("low side dropped before cycle end");
   chk_min_off: assert property ($fell(high_side_on) |=> !high_side_on) // R7
      else $error("off-time shorter than minimum");
   chk_max_on_bound: assert property (on_cnt <= 8'(buck_pkg::MAX_ON_CYC)) // R8
      else $error("on-time beyond maximum");
   chk_source_skip: assert property ((start_now && src_s) |=> !high_side_on) // R10
      else $error("turn-on despite source limit");
   chk_sink_off: assert property ( // R12
      (state == buck_pkg::sw_low && sink_s) |=> (!high_side_on && !low_side_on))
      else $error("sink limit left a switch on");
   chk_lockout_off: assert property (lock_s |=> (!high_side_on && !low_side_on)) // R14
      else $error("switching during lockout");
   chk_hiccup_entry: assert property ( // R1
      (!hiccup_active && retry_cnt > 10'(buck_pkg::RETRY_ON_CYCLES)) |=> hiccup_active)
      else $error("hiccup not entered after retry count");
   chk_hiccup_quiet: assert property (hiccup_active |=> (!high_side_on && !low_side_on)) // R19
      else $error("switch on during hiccup");

   // Hiccup timing, retry counting, cycle starts and the gating paths
   chk_entry_quiet: assert property (enter_hiccup |=> (!high_side_on && !low_side_on)) // R19
      else $error("drive on at hiccup entry");
   chk_timer_start: assert property ($rose(hiccup_active) |-> (off_timer == 24'h000000)) // R2
      else $error("off-timer not cleared at entry");
   chk_off_hold: assert property ( // R2
      (hiccup_active && off_timer < 24'(RETRY_OFF_CYC - 1)) |=> hiccup_active)
      else $error("hiccup ended early");
   chk_off_expiry: assert property ( // R19
      (hiccup_active && off_timer >= 24'(RETRY_OFF_CYC - 1)) |=> !hiccup_active)
      else $error("no restart after off-time");
   chk_fault_count: assert property ( // R15
      (run && start_now && ovp_s && retry_cnt < 10'h200) |=> (retry_cnt == $past(retry_cnt) + 10'h001))
      else $error("faulty cycle not counted");
   chk_clean_cycle: assert property ( // R1
      (run && start_now && !oc_seen && !hs_lim_s && !src_s && !sink_s && !ovp_s) |=> (retry_cnt == 10'h000))
      else $error("clean cycle kept the count");
   chk_source_hold: assert property ((start_now && src_s && run) |=> (low_side_on && !high_side_on)) // R11
      else $error("source limit did not hold low side");
   chk_sink_restart: assert property ( // R13
      (state == buck_pkg::sw_sink_off && !start_now) |=> !high_side_on)
      else $error("turn-on after sink event outside cycle start");
   chk_dim_gate: assert property ((!variant && !dim_s) |=> (!high_side_on && !low_side_on)) // R16
      else $error("switching while dimming low");
   chk_dim_idle: assert property (dim_disabled |=> (!high_side_on && !low_side_on)) // R18
      else $error("switching while disabled");
   chk_dim_release: assert property (dim_s |=> !dim_disabled) // R18
      else $error("disable held with dimming high");
   chk_ramp_restart: assert property ((lock_s || dim_disabled || hiccup_active) |=> (ramp == 10'h000)) // R3
      else $error("ramp not restarted");
   chk_ramp_rise: assert property ( // R3
      (!lock_s && !dim_disabled && !hiccup_active) |=> (ramp >= $past(ramp)))
      else $error("ramp fell while running");
   chk_on_start: assert property ( // R4
      (start_now && run && !src_s && !sink_s) |=> high_side_on)
      else $error("no turn-on at cycle start");
   chk_stretch_end: assert property ( // R8
      (state == buck_pkg::sw_on && on_cnt >= 8'(buck_pkg::MAX_ON_CYC - 1)) |=> !high_side_on)
      else $error("on-time not ended at maximum");

   // Main scenarios
   cov_hiccup: cover property ($rose(hiccup_active));
   cov_stretch: cover property (on_cnt > 8'(P));
   cov_sink: cover property (state == buck_pkg::sw_sink_off);
   cov_dim_off: cover property ($rose(dim_disabled));
   cov_source_skip: cover property (start_now && src_s && run);

endmodule // buck_switch_control_hiccup

// >>> tb/comparator_model.sv
`timescale 1ns/1ps
module comparator_model (
   input  wire logic       mclk,         // Core clock
   input  wire logic       high_side_on, // High-side drive from the controller
   input  wire logic [7:0] trip_after,   // On cycles before tripping, 0 = never
   output logic            peak_compare  // Peak current comparator output
);
   int on_cnt;
   initial begin
      on_cnt       = 0;
      peak_compare = 1'h0;
   end
   // Moves on the falling edge so the pin never changes with a sampling edge
   always @(negedge mclk) begin
      on_cnt       = (high_side_on === 1'h1) ? on_cnt + 1 : 0;
      peak_compare = (trip_after != 8'h00) && (on_cnt >= int'(trip_after));
   end
endmodule // comparator_model

// >>> tb/tb_buck_switch_control_hiccup.sv
`timescale 1ns/1ps
module tb_buck_switch_control_hiccup;
   localparam int RETRY_OFF = 200;
   localparam int DIM_OFF   = 300;
   localparam int PER       = buck_pkg::PERIOD_CYC;
   logic       mclk;
   logic       sys_rst;
   logic       peak_compare;
   logic       hs_lim;
   logic       src_lim;
   logic       sink_lim;
   logic       lockout;
   logic       ovp;
   logic       dim_in;
   logic       high_side_on;
   logic       low_side_on;
   logic [9:0] reference_level;
   logic       hiccup_active;
   logic       dim_disabled;
   logic [7:0] trip;
   logic       strap;
   int         error_cnt;
   int         n_compared;

   buck_switch_control_hiccup #(.RETRY_OFF_CYC(RETRY_OFF), .SS_CYC(1024), .DIM_OFF_CYC(DIM_OFF)) DUT (
      .mclk(mclk), .sys_rst(sys_rst), .peak_compare(peak_compare), .high_side_current_limit(hs_lim),
      .low_side_source_limit(src_lim), .low_side_sink_limit(sink_lim), .supply_lockout(lockout),
      .feedback_pin_ovp(ovp), .dimming_input(dim_in), .duty_scale_variant(strap),
      .high_side_on(high_side_on), .low_side_on(low_side_on), .reference_level(reference_level),
      .hiccup_active(hiccup_active), .dim_disabled(dim_disabled));
   comparator_model partner (.mclk(mclk), .high_side_on(high_side_on), .trip_after(trip),
      .peak_compare(peak_compare));

   initial begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return high_side_on;
         1: return low_side_on;
         2: return hiccup_active;
         default: return dim_disabled;
      endcase
   endfunction

   // Bounded wait; running out of patience ends the run as a mismatch
   task automatic waitfor(input int k, input logic v, input int bound, output int n);
      n = 0;
      while (sig(k) !== v) begin
         if (n >= bound) begin
            error_cnt++;
            $display("mismatch at %0t: wait %0d timed out", $time, k);
            results();
         end
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic measure(output int ton, output int toff, output logic ls_ok);
      int n;
      waitfor(0, 1'h0, 300, n);
      waitfor(0, 1'h1, 300, n);
      ton = 0;
      toff = 0;
      ls_ok = 1'h1;
      while (high_side_on === 1'h1 && ton < 300) begin
         @(negedge mclk);
         ton++;
      end
      while (high_side_on === 1'h0 && toff < 300) begin
         if (low_side_on !== 1'h1) ls_ok = 1'h0;
         @(negedge mclk);
         toff++;
      end
   endtask

   task automatic t_ramp();
      logic [9:0] last;
      logic       mono;
      int         n;
      last = 10'h000;
      mono = 1'h1;
      n = 0;
      while (reference_level !== 10'h3FF && n < 1300) begin
         if (reference_level < last) mono = 1'h0;
         last = reference_level;
         @(negedge mclk);
         n++;
      end
      check(mono, "reference falls during ramp");
      check(n >= 900 && n <= 1200, "ramp length");
      $display("test ramp done");
   endtask

   task automatic t_cycles();
      int   ton;
      int   toff;
      logic ls_ok;
      measure(ton, toff, ls_ok);
      check(ls_ok, "low side not on through off phase");
      check(ton + toff == PER, "switching period");
      trip = 8'h00;
      measure(ton, toff, ls_ok);
      measure(ton, toff, ls_ok);
      check(ton == buck_pkg::MAX_ON_CYC, "stretched on-time");
      check(toff >= buck_pkg::MIN_OFF_CYC, "minimum off-time");
      trip = 8'h08;
      $display("test cycles done");
   endtask

   task automatic t_limits();
      int n;
      trip = 8'h00;
      waitfor(0, 1'h1, 300, n);
      repeat (10) @(negedge mclk);
      hs_lim = 1'h1;
      waitfor(0, 1'h0, 8, n);
      check(low_side_on === 1'h1, "low side after high-side limit");
      hs_lim = 1'h0;
      trip = 8'h08;
      waitfor(0, 1'h1, 300, n);
      waitfor(0, 1'h0, 30, n);
      src_lim = 1'h1;
      repeat (100) begin
         @(negedge mclk);
         check(high_side_on === 1'h0 && low_side_on === 1'h1, "turn-on not skipped");
      end
      src_lim = 1'h0;
      waitfor(0, 1'h1, 60, n);
      check(high_side_on === 1'h1 && n <= PER + 6, "turn-on not resumed");
      waitfor(0, 1'h0, 30, n);
      sink_lim = 1'h1;
      repeat (3) @(negedge mclk);
      sink_lim = 1'h0;
      repeat (3) @(negedge mclk);
      check(high_side_on === 1'h0 && low_side_on === 1'h0, "sink limit drives");
      n = 0;
      while (high_side_on !== 1'h1 && n < 30) begin
         check(low_side_on === 1'h0, "low side back before new cycle");
         @(negedge mclk);
         n++;
      end
      check(high_side_on === 1'h1 && low_side_on === 1'h0, "restart after sink event");
      $display("test limits done");
   endtask

   task automatic t_gate();
      int n;
      lockout = 1'h1;
      repeat (8) @(negedge mclk);
      repeat (60) begin
         @(negedge mclk);
         check(high_side_on === 1'h0 && low_side_on === 1'h0, "switching in lockout");
      end
      lockout = 1'h0;
      waitfor(0, 1'h1, 100, n);
      dim_in = 1'h0;
      repeat (8) @(negedge mclk);
      repeat (50) begin
         @(negedge mclk);
         check(high_side_on === 1'h0 && low_side_on === 1'h0, "switching while dim low");
      end
      waitfor(3, 1'h1, 400, n);
      check(n + 58 >= DIM_OFF && n + 58 <= DIM_OFF + 10, "disable time");
      dim_in = 1'h1;
      waitfor(3, 1'h0, 10, n);
      waitfor(0, 1'h1, 100, n);
      check(low_side_on === 1'h0, "restart after dimming");
      $display("test gate done");
   endtask

   task automatic t_hiccup();
      int   n;
      int   k;
      logic off_ok;
      ovp = 1'h1;
      waitfor(2, 1'h1, 14000, n);
      check(n >= 512 * PER && n <= 514 * PER + 10, "retry on-time");
      off_ok = 1'h1;
      k = 0;
      while (hiccup_active === 1'h1 && k < 400) begin
         if (high_side_on !== 1'h0 || low_side_on !== 1'h0) off_ok = 1'h0;
         @(negedge mclk);
         k++;
      end
      check(off_ok, "drive during shutdown");
      check(k == RETRY_OFF, "retry off-time");
      check(reference_level < 10'h020, "ramp not restarted");
      waitfor(0, 1'h1, 100, n);
      waitfor(2, 1'h1, 14000, n);
      check(n >= 511 * PER, "second shutdown");
      ovp = 1'h0;
      waitfor(2, 1'h0, 400, n);
      $display("test hiccup done");
   endtask

   // Mid-run reset with the strap high selects duty scaling of the reference
   task automatic t_scale();
      int n;
      strap = 1'h1;
      sys_rst = 1'h1;
      repeat (2) @(negedge mclk);
      check(high_side_on === 1'h0 && low_side_on === 1'h0 && reference_level === 10'h000, "mid-run reset outputs");
      sys_rst = 1'h0;
      dim_in = 1'h0;
      repeat (60) @(negedge mclk);
      check(high_side_on === 1'h1 || low_side_on === 1'h1, "scaling variant gated by dimming");
      dim_in = 1'h1;
      n = 0;
      while (reference_level !== 10'h3FF && n < 1300) begin
         @(negedge mclk);
         n++;
      end
      check(n >= 900 && n <= 1200, "scaled reference at full duty");
      $display("test scale done");
   endtask

   // Both drives high together is never legal
   always @(negedge mclk) begin
      if (sys_rst === 1'h0 && high_side_on === 1'h1 && low_side_on === 1'h1) check(1'h0, "both drives on");
   end

   initial begin
      error_cnt = 0;
      n_compared = 0;
      sys_rst = 1'h1;
      hs_lim = 1'h0;
      src_lim = 1'h0;
      sink_lim = 1'h0;
      lockout = 1'h0;
      ovp = 1'h0;
      dim_in = 1'h1;
      trip = 8'h08;
      strap = 1'h0;
      repeat (5) @(negedge mclk);
      check(high_side_on === 1'h0 && low_side_on === 1'h0 && hiccup_active === 1'h0, "reset outputs");
      sys_rst = 1'h0;
      t_ramp();
      t_cycles();
      t_limits();
      t_gate();
      t_hiccup();
      t_scale();
      results();
   end
endmodule // tb_buck_switch_control_hiccup
